// >>> hdl/emx_core.sv
// execute datapath for extended instructions that act on a data memory byte
// Function
// RULE1 - moves copy byte, flags untouched
// RULE2 - or to acc or memory, zero only
// RULE3 - rotate left, top bit into bit0
// RULE4 - rotate left through carry
// RULE5 - rotate right, bit0 into top bit
// RULE6 - rotate right through carry
// RULE7 - acc rotate forms leave memory intact
// RULE8 - subtract acc, memory and inverted carry
// RULE9 - plain subtract ignores carry input
// RULE10 - carry is one when no borrow
// RULE11 - subtracts update all six flags
// RULE12 - decrement memory, skip when zero
// RULE13 - increment memory, skip when zero
// RULE14 - acc forms write acc, skip on zero
// RULE15 - taken skip costs dummy second cycle
// RULE16 - byte set loads all ones
// RULE17 - bit set forces one bit
// RULE18 - skip when selected bit is one
// RULE19 - skip when byte is non-zero
// RULE20 - zero flag follows result byte
`include "emx_consts.svh"

module emx_core
  import emx_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // instruction request from the sequencer
  input wire logic OP_VALID,
  output logic OP_READY,
  input emx_req_t OP_REQ,
  // data memory write-back
  output logic MEM_WE,
  output logic [7:0] MEM_WDATA,
  // architectural state
  output logic [7:0] ACCUMULATOR_REG,
  output emx_flags_t STATUS_FLAGS,
  // sequencing
  output logic SKIP_NEXT,
  output logic DUMMY_SLOT
);

  emx_state_t state_q;
  emx_state_t state_d;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  emx_flags_t flg_q;
  emx_flags_t flg_d;
  logic we_q;
  logic we_d;
  logic [7:0] wd_q;
  logic [7:0] wd_d;
  logic skip_q;
  logic skip_d;

  wire logic taken;
  wire logic [7:0] m;
  wire logic [7:0] rol_v;
  wire logic [7:0] rolc_v;
  wire logic [7:0] ror_v;
  wire logic [7:0] rorc_v;
  wire logic [7:0] or_v;
  wire logic [7:0] dec_v;
  wire logic [7:0] inc_v;
  wire logic [7:0] bit_mask;
  wire logic use_borrow;
  wire logic borrow_in;
  wire logic [8:0] diff9;
  wire logic [4:0] diff_lo;
  wire logic [7:0] diff_v;
  wire logic diff_ov;
  wire logic diff_z;
  emx_flags_t sub_flags;

  assign taken = OP_VALID && OP_READY;
  assign m = OP_REQ.mem_byte;
  assign rol_v = {m[6:0], m[`EMX_BIT_TOP]}; // [RULE3]
  assign rolc_v = {m[6:0], flg_q.c}; // [RULE4]
  assign ror_v = {m[`EMX_BIT_LOW], m[7:1]}; // [RULE5]
  assign rorc_v = {flg_q.c, m[7:1]}; // [RULE6]
  assign or_v = acc_q | m; // [RULE2]
  assign dec_v = m - `EMX_BYTE_ONE; // [RULE12]
  assign inc_v = m + `EMX_BYTE_ONE; // [RULE13]
  assign bit_mask = `EMX_BYTE_ONE << OP_REQ.bit_sel;

  // borrow-in is the inverted carry only for the with-borrow pair
  assign use_borrow = (OP_REQ.op == EXT_SUBTRACT_BORROW)
    || (OP_REQ.op == EXT_SUBTRACT_BORROW_TO_MEMORY);
  assign borrow_in = use_borrow & ~flg_q.c; // [RULE8] [RULE9]
  assign diff9 = {1'b0, acc_q} - {1'b0, m} - {8'h00, borrow_in};
  assign diff_lo = {1'b0, acc_q[3:0]} - {1'b0, m[3:0]} - {4'h0, borrow_in};
  assign diff_v = diff9[7:0];
  assign diff_ov = (acc_q[7] ^ m[7]) & (acc_q[7] ^ diff_v[7]);
  assign diff_z = (diff_v == `EMX_BYTE_ZERO); // [RULE20]

  // the combined zero chains across bytes only in the with-borrow pair
  always_comb
  begin
    sub_flags.overflow_flag = diff_ov; // [RULE11]
    sub_flags.z = diff_z;
    sub_flags.aux_carry_flag = ~diff_lo[4];
    sub_flags.c = ~diff9[8]; // [RULE10]
    sub_flags.signed_compare_flag = ~(diff_v[7] ^ diff_ov);
    sub_flags.combined_zero_flag = use_borrow ? (diff_z & flg_q.combined_zero_flag) : diff_z;
  end

  always_comb
  begin
    acc_d = acc_q;
    flg_d = flg_q;
    we_d = 1'b0;
    wd_d = wd_q;
    skip_d = 1'b0;
    if (taken)
    begin
      case (OP_REQ.op)
        EXT_MOVE_TO_ACC: acc_d = m; // [RULE1]
        EXT_MOVE_TO_MEM:
        begin
          we_d = 1'b1; // [RULE1]
          wd_d = acc_q;
        end
        EXT_OR_TO_ACC:
        begin
          acc_d = or_v; // [RULE2]
          flg_d.z = (or_v == `EMX_BYTE_ZERO); // [RULE20]
        end
        EXT_OR_TO_MEMORY:
        begin
          we_d = 1'b1; // [RULE2]
          wd_d = or_v;
          flg_d.z = (or_v == `EMX_BYTE_ZERO); // [RULE20]
        end
        EXT_ROTATE_LEFT:
        begin
          we_d = 1'b1; // [RULE3]
          wd_d = rol_v;
        end
        EXT_ROTATE_LEFT_TO_ACC: acc_d = rol_v; // [RULE7]
        EXT_ROTATE_LEFT_CARRY:
        begin
          we_d = 1'b1;
          wd_d = rolc_v;
          flg_d.c = m[`EMX_BIT_TOP]; // [RULE4]
        end
        EXT_ROTATE_LEFT_CARRY_TO_ACC:
        begin
          acc_d = rolc_v; // [RULE7]
          flg_d.c = m[`EMX_BIT_TOP];
        end
        EXT_ROTATE_RIGHT:
        begin
          we_d = 1'b1; // [RULE5]
          wd_d = ror_v;
        end
        EXT_ROTATE_RIGHT_TO_ACC: acc_d = ror_v; // [RULE7]
        EXT_ROTATE_RIGHT_CARRY:
        begin
          we_d = 1'b1;
          wd_d = rorc_v;
          flg_d.c = m[`EMX_BIT_LOW]; // [RULE6]
        end
        EXT_ROTATE_RIGHT_CARRY_TO_ACC:
        begin
          acc_d = rorc_v; // [RULE7]
          flg_d.c = m[`EMX_BIT_LOW];
        end
        EXT_SUBTRACT_BORROW, EXT_SUBTRACT:
        begin
          acc_d = diff_v; // [RULE8] [RULE9]
          flg_d = sub_flags; // [RULE11]
        end
        EXT_SUBTRACT_BORROW_TO_MEMORY, EXT_SUBTRACT_TO_MEMORY:
        begin
          we_d = 1'b1; // [RULE8] [RULE9]
          wd_d = diff_v;
          flg_d = sub_flags; // [RULE11]
        end
        EXT_DECREMENT_SKIP_ZERO:
        begin
          we_d = 1'b1; // [RULE12]
          wd_d = dec_v;
          skip_d = (dec_v == `EMX_BYTE_ZERO);
        end
        EXT_DECREMENT_SKIP_ZERO_TO_ACC:
        begin
          acc_d = dec_v; // [RULE14]
          skip_d = (dec_v == `EMX_BYTE_ZERO);
        end
        EXT_INCREMENT_SKIP_ZERO:
        begin
          we_d = 1'b1; // [RULE13]
          wd_d = inc_v;
          skip_d = (inc_v == `EMX_BYTE_ZERO);
        end
        EXT_INCREMENT_SKIP_ZERO_TO_ACC:
        begin
          acc_d = inc_v; // [RULE14]
          skip_d = (inc_v == `EMX_BYTE_ZERO);
        end
        EXT_SET_ALL:
        begin
          we_d = 1'b1; // [RULE16]
          wd_d = `EMX_BYTE_ONES;
        end
        EXT_SET_BIT:
        begin
          we_d = 1'b1; // [RULE17]
          wd_d = m | bit_mask;
        end
        EXT_SKIP_NONZERO_BIT: skip_d = |(m & bit_mask); // [RULE18]
        EXT_SKIP_NONZERO: skip_d = (m != `EMX_BYTE_ZERO); // [RULE19]
        default: skip_d = 1'b0;
      endcase
    end
  end

  // a taken skip holds off the next request for the dummy slot
  always_comb
  begin
    case (state_q)
      EMX_RUN: state_d = skip_d ? EMX_DUMMY : EMX_RUN; // [RULE15]
      EMX_DUMMY: state_d = EMX_RUN;
      default: state_d = EMX_RUN;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_q <= EMX_RUN;
      acc_q <= `EMX_ACC_RESET;
      flg_q <= '0;
      we_q <= 1'b0;
      wd_q <= `EMX_BYTE_ZERO;
      skip_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      acc_q <= acc_d;
      flg_q <= flg_d;
      we_q <= we_d;
      wd_q <= wd_d;
      skip_q <= skip_d;
    end
  end

  assign OP_READY = (state_q == EMX_RUN);
  assign DUMMY_SLOT = (state_q == EMX_DUMMY);
  assign MEM_WE = we_q;
  assign MEM_WDATA = wd_q;
  assign ACCUMULATOR_REG = acc_q;
  assign STATUS_FLAGS = flg_q;
  assign SKIP_NEXT = skip_q;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_take(emx_op_t o);
    OP_VALID && OP_READY && (OP_REQ.op == o);
  endsequence

  sequence s_dummy;
    SKIP_NEXT && DUMMY_SLOT && !OP_READY ##1 OP_READY && !DUMMY_SLOT;
  endsequence

  chk_move_flags: assert property (s_take(EXT_MOVE_TO_MEM) |=> // [RULE1]
    MEM_WE && MEM_WDATA == $past(acc_q) && $stable(STATUS_FLAGS))
    else $error("move to memory wrong");
  chk_or_acc: assert property (s_take(EXT_OR_TO_ACC) |=> // [RULE2]
    acc_q == ($past(acc_q) | $past(m)) && !MEM_WE
    && STATUS_FLAGS.c == $past(flg_q.c))
    else $error("or to acc wrong");
  chk_rol_mem: assert property (s_take(EXT_ROTATE_LEFT) |=> // [RULE3]
    MEM_WE && MEM_WDATA == {$past(m[6:0]), $past(m[7])} && $stable(STATUS_FLAGS))
    else $error("rotate left wrong");
  chk_rolc_carry: assert property (s_take(EXT_ROTATE_LEFT_CARRY) |=> // [RULE4]
    MEM_WDATA[0] == $past(flg_q.c) && STATUS_FLAGS.c == $past(m[7]))
    else $error("rotate left carry wrong");
  chk_ror_mem: assert property (s_take(EXT_ROTATE_RIGHT) |=> // [RULE5]
    MEM_WE && MEM_WDATA == {$past(m[0]), $past(m[7:1])})
    else $error("rotate right wrong");
  chk_rorc_carry: assert property (s_take(EXT_ROTATE_RIGHT_CARRY) |=> // [RULE6]
    MEM_WDATA[7] == $past(flg_q.c) && STATUS_FLAGS.c == $past(m[0]))
    else $error("rotate right carry wrong");
  chk_rot_acc: assert property (s_take(EXT_ROTATE_RIGHT_CARRY_TO_ACC) |=> // [RULE7]
    !MEM_WE && acc_q[7] == $past(flg_q.c) && STATUS_FLAGS.c == $past(m[0]))
    else $error("rotate to acc wrote memory");
  chk_sbc_value: assert property (s_take(EXT_SUBTRACT_BORROW_TO_MEMORY) |=> // [RULE8]
    MEM_WE && MEM_WDATA == 8'($past(acc_q) - $past(m) - {7'h00, ~$past(flg_q.c)}))
    else $error("subtract with borrow wrong");
  chk_sub_value: assert property (s_take(EXT_SUBTRACT) |=> // [RULE9]
    acc_q == 8'($past(acc_q) - $past(m)) && !MEM_WE)
    else $error("subtract wrong");
  chk_sub_carry: assert property (s_take(EXT_SUBTRACT) |=> // [RULE10]
    STATUS_FLAGS.c == ($past(acc_q) >= $past(m)))
    else $error("subtract carry wrong");
  chk_sub_zero: assert property (s_take(EXT_SUBTRACT_TO_MEMORY) |=> // [RULE11]
    STATUS_FLAGS.z == (MEM_WDATA == 8'h00) && STATUS_FLAGS.combined_zero_flag == STATUS_FLAGS.z)
    else $error("subtract flags wrong");
  chk_dec_skip: assert property (s_take(EXT_DECREMENT_SKIP_ZERO) |=> // [RULE12]
    MEM_WE && MEM_WDATA == 8'($past(m) - 8'h01) && SKIP_NEXT == (MEM_WDATA == 8'h00)
    && $stable(STATUS_FLAGS))
    else $error("decrement skip wrong");
  chk_inc_skip: assert property (s_take(EXT_INCREMENT_SKIP_ZERO) |=> // [RULE13]
    MEM_WE && MEM_WDATA == 8'($past(m) + 8'h01) && SKIP_NEXT == (MEM_WDATA == 8'h00))
    else $error("increment skip wrong");
  chk_acc_skip: assert property (s_take(EXT_INCREMENT_SKIP_ZERO_TO_ACC) |=> // [RULE14]
    !MEM_WE && SKIP_NEXT == (acc_q == 8'h00))
    else $error("acc skip wrong");
  chk_skip_dummy: assert property (skip_d && OP_VALID |=> s_dummy) // [RULE15]
    else $error("skip without dummy slot");
  chk_set_all: assert property (s_take(EXT_SET_ALL) |=> // [RULE16]
    MEM_WE && MEM_WDATA == 8'hff && $stable(STATUS_FLAGS))
    else $error("byte set wrong");
  chk_set_bit: assert property (s_take(EXT_SET_BIT) |=> // [RULE17]
    MEM_WDATA == ($past(m) | (8'h01 << $past(OP_REQ.bit_sel))))
    else $error("bit set wrong");
  chk_snz_bit: assert property (s_take(EXT_SKIP_NONZERO_BIT) |=> // [RULE18]
    SKIP_NEXT == $past(m[OP_REQ.bit_sel]) && !MEM_WE)
    else $error("bit skip wrong");
  chk_snz_byte: assert property (s_take(EXT_SKIP_NONZERO) |=> // [RULE19]
    SKIP_NEXT == ($past(m) != 8'h00) && $stable(acc_q))
    else $error("byte skip wrong");
  chk_zero_flag: assert property (s_take(EXT_OR_TO_MEMORY) |=> // [RULE20]
    STATUS_FLAGS.z == (MEM_WDATA == 8'h00))
    else $error("zero flag wrong");
  chk_move_acc: assert property (s_take(EXT_MOVE_TO_ACC) |=> // [RULE1]
    acc_q == $past(m) && !MEM_WE && $stable(STATUS_FLAGS))
    else $error("move to acc wrong");
  chk_rol_acc: assert property (s_take(EXT_ROTATE_LEFT_TO_ACC) |=> // [RULE7]
    !MEM_WE && acc_q == {$past(m[6:0]), $past(m[7])} && $stable(STATUS_FLAGS))
    else $error("rotate left to acc wrong");
  chk_dec_acc: assert property (s_take(EXT_DECREMENT_SKIP_ZERO_TO_ACC) |=> // [RULE14]
    !MEM_WE && acc_q == 8'($past(m) - 8'h01) && SKIP_NEXT == (acc_q == 8'h00))
    else $error("decrement to acc wrong");

endmodule

// >>> include/emx_consts.svh
// constants for the extended memory-operand execute datapath
`ifndef EMX_CONSTS_SVH
`define EMX_CONSTS_SVH
`define EMX_ACC_RESET 8'h00
`define EMX_BYTE_ZERO 8'h00
`define EMX_BYTE_ONES 8'hff
`define EMX_BYTE_ONE 8'h01
`define EMX_BIT_TOP 7
`define EMX_BIT_LOW 0
`define EMX_SKIP_CYCLES 2
`endif

// >>> include/emx_pkg.sv
// types shared by the extended memory-operand execute datapath
package emx_pkg;
  typedef enum logic [4:0] {
    EXT_MOVE_TO_ACC = 5'h00,
    EXT_MOVE_TO_MEM = 5'h01,
    EXT_OR_TO_ACC = 5'h02,
    EXT_OR_TO_MEMORY = 5'h03,
    EXT_ROTATE_LEFT = 5'h04,
    EXT_ROTATE_LEFT_TO_ACC = 5'h05,
    EXT_ROTATE_LEFT_CARRY = 5'h06,
    EXT_ROTATE_LEFT_CARRY_TO_ACC = 5'h07,
    EXT_ROTATE_RIGHT = 5'h08,
    EXT_ROTATE_RIGHT_TO_ACC = 5'h09,
    EXT_ROTATE_RIGHT_CARRY = 5'h0a,
    EXT_ROTATE_RIGHT_CARRY_TO_ACC = 5'h0b,
    EXT_SUBTRACT_BORROW = 5'h0c,
    EXT_SUBTRACT_BORROW_TO_MEMORY = 5'h0d,
    EXT_SUBTRACT = 5'h0e,
    EXT_SUBTRACT_TO_MEMORY = 5'h0f,
    EXT_DECREMENT_SKIP_ZERO = 5'h10,
    EXT_DECREMENT_SKIP_ZERO_TO_ACC = 5'h11,
    EXT_INCREMENT_SKIP_ZERO = 5'h12,
    EXT_INCREMENT_SKIP_ZERO_TO_ACC = 5'h13,
    EXT_SET_ALL = 5'h14,
    EXT_SET_BIT = 5'h15,
    EXT_SKIP_NONZERO_BIT = 5'h16,
    EXT_SKIP_NONZERO = 5'h17
  } emx_op_t;

  typedef enum logic {
    EMX_RUN = 1'b0,
    EMX_DUMMY = 1'b1
  } emx_state_t;

  typedef struct packed {
    emx_op_t op;
    logic [7:0] mem_byte;
    logic [2:0] bit_sel;
  } emx_req_t;

  typedef struct packed {
    logic overflow_flag;
    logic z;
    logic aux_carry_flag;
    logic c;
    logic signed_compare_flag;
    logic combined_zero_flag;
  } emx_flags_t;
endpackage

// >>> verif/emx_mem_model.sv
// data memory model standing behind the execute block
module emx_mem_model
(
  // clock
  input wire logic clk,
  // access from the sequencer side
  input wire logic take,
  input wire logic [3:0] addr,
  output logic [7:0] rdata,
  // write-back from the block
  input wire logic we,
  input wire logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [16];
  logic [3:0] wa_q;
  // the write lands one edge late, so a read of the same byte is forwarded
  assign rdata = (we && addr == wa_q) ? wdata : mem[addr];
  always @(posedge clk)
  begin
    if (we)
      mem[wa_q] <= wdata;
    if (take)
      wa_q <= addr;
  end
endmodule

// >>> verif/extended_memory_op_execute_tb.sv
// self-checking bench for the extended memory-operand execute block
module extended_memory_op_execute_tb
  import emx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic op_valid = 1'b0;
  emx_op_t op = EXT_MOVE_TO_ACC;
  logic [3:0] addr = 4'h0;
  logic [2:0] bsel = 3'h0;
  logic op_ready, mem_we, skip_next, dummy_slot;
  logic [7:0] mem_wdata, acc, rdata;
  emx_flags_t flags, saved;
  emx_req_t req;
  int failures = 0;
  int total_checks = 0;
  assign req = {op, rdata, bsel};
  emx_core DUT (.CLK(clk), .RESET_N(reset_n), .OP_VALID(op_valid), .OP_READY(op_ready),
    .OP_REQ(req), .MEM_WE(mem_we), .MEM_WDATA(mem_wdata), .ACCUMULATOR_REG(acc),
    .STATUS_FLAGS(flags), .SKIP_NEXT(skip_next), .DUMMY_SLOT(dummy_slot));
  emx_mem_model mem_i (.clk(clk), .take(op_valid & op_ready), .addr(addr), .rdata(rdata),
    .we(mem_we), .wdata(mem_wdata));
  initial
  begin
    forever #2 clk = ~clk;
  end
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task fchk(input string what);
    chk(what, {2'b00, saved}, {2'b00, flags});
  endtask
  task ld(input logic [3:0] a, input logic [7:0] v);
    mem_i.mem[a] = v;
  endtask
  // valid stays up between ops; a held-off request waits out the dummy slot
  task run(input emx_op_t o, input logic [3:0] a, input logic [2:0] b = 3'h0);
    int n;
    n = 0;
    saved = flags;
    op = o;
    addr = a;
    bsel = b;
    op_valid = 1'b1;
    while (op_ready !== 1'b1 && n < 4)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("ready wait", 8'h00, {7'h0, n == 4});
    @(posedge clk);
    #1;
  endtask
  task setc(input logic c);
    ld(4'hf, {c, 7'h00});
    run(EXT_ROTATE_LEFT_CARRY_TO_ACC, 4'hf);
  endtask
  task automatic t_sub();
    logic [31:0] tab [4] = '{32'h0e800100, 32'h0f050500, 32'h0c050601, 32'h0d100f00};
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] a, m, e;
    logic bi, sgn_ovf, z, chain_z;
    foreach (tab[k])
    begin
      {a, m} = tab[k][23:8];
      setc(tab[k][0]);
      ld(4'h6, a);
      run(EXT_MOVE_TO_ACC, 4'h6);
      ld(4'h7, m);
      run(emx_op_t'(tab[k][28:24]), 4'h7);
      bi = ~tab[k][25] & ~tab[k][0];
      r = {1'b0, a} - {1'b0, m} - 9'(bi);
      h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - 5'(bi);
      sgn_ovf = (a[7] ^ m[7]) & (r[7] ^ a[7]);
      z = r[7:0] == 8'h00;
      chain_z = tab[k][25] ? z : z & saved.combined_zero_flag;
      chk("sub result", r[7:0], tab[k][24] ? mem_wdata : acc);
      e = {2'b00, sgn_ovf, z, ~h[4], ~r[8], ~(r[7] ^ sgn_ovf), chain_z};
      chk("sub flags", e, {2'b00, flags});
    end
  endtask
  task t_move();
    ld(4'h1, 8'ha5);
    run(EXT_MOVE_TO_ACC, 4'h1);
    chk("move acc", 8'ha5, acc);
    fchk("move flags");
    run(EXT_MOVE_TO_MEM, 4'h2);
    chk("move wdata", 8'ha5, mem_wdata);
    chk("move we", 8'h01, {7'h0, mem_we});
  endtask
  task t_or();
    ld(4'h3, 8'h0f);
    run(EXT_OR_TO_ACC, 4'h3);
    chk("or acc", 8'haf, acc);
    chk("or z", 8'h00, {7'h0, flags.z});
    chk("or others", {2'b00, saved} | 8'h10, {2'b00, flags} | 8'h10);
    ld(4'h4, 8'h00);
    run(EXT_MOVE_TO_ACC, 4'h4);
    run(EXT_OR_TO_MEMORY, 4'h4);
    chk("or wdata", 8'h00, mem_wdata);
    chk("or we", 8'h01, {7'h0, mem_we});
    chk("or z set", 8'h01, {7'h0, flags.z});
  endtask
  task automatic t_rot();
    logic [7:0] b, e;
    logic c, co;
    b = 8'h96;
    for (int i = 4; i < 12; i++)
    begin
      c = i[0];
      setc(c);
      ld(4'h5, b);
      run(emx_op_t'(i[4:0]), 4'h5);
      e = (i < 8) ? {b[6:0], i[1] ? c : b[7]} : {i[1] ? c : b[0], b[7:1]};
      co = i[1] ? ((i < 8) ? b[7] : b[0]) : c;
      chk("rotate", e, i[0] ? acc : mem_wdata);
      chk("rotate we", {7'h0, ~i[0]}, {7'h0, mem_we});
      chk("rotate flags", {2'b00, saved[5:3], co, saved[1:0]}, {2'b00, flags});
    end
  endtask
  task automatic t_skip();
    logic [15:0] tab [5] = '{16'h1001, 16'h1105, 16'h12ff, 16'h13ff, 16'h1205};
    logic [7:0] r;
    foreach (tab[k])
    begin
      ld(4'h8 + 4'(k), tab[k][7:0]);
      run(emx_op_t'(tab[k][12:8]), 4'h8 + 4'(k));
      r = tab[k][9] ? tab[k][7:0] + 8'h01 : tab[k][7:0] - 8'h01;
      chk("skip result", r, tab[k][8] ? acc : mem_wdata);
      chk("skip we", {7'h0, ~tab[k][8]}, {7'h0, mem_we});
      chk("skip pulse", {6'h0, r == 8'h00, r == 8'h00}, {6'h0, skip_next, dummy_slot});
      chk("skip ready", {7'h0, r != 8'h00}, {7'h0, op_ready});
      fchk("skip flags");
    end
  endtask
  task t_set();
    ld(4'hd, 8'h00);
    run(EXT_SET_ALL, 4'hd);
    chk("set all", 8'hff, mem_wdata);
    fchk("set flags");
    ld(4'he, 8'h41);
    run(EXT_SET_BIT, 4'he, 3'h3);
    chk("set bit", 8'h49, mem_wdata);
    run(EXT_SKIP_NONZERO_BIT, 4'he, 3'h3);
    chk("bit one", 8'h01, {7'h0, skip_next});
    run(EXT_SKIP_NONZERO_BIT, 4'he, 3'h2);
    chk("bit zero", 8'h00, {7'h0, skip_next});
    run(EXT_SKIP_NONZERO, 4'he);
    chk("byte set", 8'h01, {7'h0, skip_next});
    ld(4'hc, 8'h00);
    run(EXT_SKIP_NONZERO, 4'hc);
    chk("byte zero", 8'h00, {7'h0, skip_next});
    fchk("nz flags");
  endtask
  task wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk("reset acc", 8'h00, acc);
    chk("reset flags", 8'h00, {2'b00, flags});
    chk("reset ready", 8'h01, {7'h0, op_ready});
    t_sub();
    t_move();
    t_or();
    t_rot();
    t_skip();
    t_set();
    wrap_up();
  end
  // under fifty ops in all; this span is far beyond them
  initial
  begin
    #20000;
    failures++;
    wrap_up();
  end
endmodule
